// ==== verilog/cfsp_pkg.sv ====
package cfsp_pkg;
    localparam int FLAG_H = 4;
    localparam int FLAG_I = 3;
    localparam int FLAG_N = 2;
    localparam int FLAG_Z = 1;
    localparam int FLAG_C = 0;
    localparam int SIGN_BIT = 7;
    localparam logic [7:0] FLAGS_FIXED = 8'hE0;
    localparam logic [7:0] FLAGS_RESET = 8'hE8;
    localparam logic [15:0] SP_TOP = 16'h017F;
    localparam logic [15:0] SP_HIGH_MASK = 16'hFFC0;
    localparam logic [5:0] SP_LOW_MASK = 6'h3F;
    localparam logic [2:0] CTX_BYTES = 3'h5;
    localparam logic [2:0] CALL_BYTES = 3'h2;

    // Stack transfer kinds requested by the sequencer
    typedef enum logic [2:0] {
        CFSP_ST_NONE, CFSP_ST_PUSH, CFSP_ST_POP, CFSP_ST_CALL,
        CFSP_ST_RET, CFSP_ST_IENTRY, CFSP_ST_RETURN_FROM_INTERRUPT
    } cfsp_stk_t;

    // Flag update request from the ALU
    typedef struct packed {
        logic       upd_nz;
        logic       upd_h;
        logic       upd_c;
        logic [7:0] result;
        logic       half_carry;
        logic       carry;
    } cfsp_alu_t;

    // Single-flag instructions
    typedef struct packed {
        logic set_mask;
        logic clr_mask;
        logic set_carry;
        logic clr_carry;
    } cfsp_flagop_t;

    // Stack memory cycle presented to the RAM
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [15:0] addr;
        logic [2:0]  index;
    } cfsp_mem_t;
endpackage

// ==== verilog/cfsp_regs.sv ====
`timescale 1ns/1ps
module cfsp_regs (
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    // ALU and flag instructions
    input  wire cfsp_pkg::cfsp_alu_t    alu,
    input  wire cfsp_pkg::cfsp_flagop_t flagop,
    // Direct register transfers
    input  wire logic                  flags_wr,
    input  wire logic [7:0]            flags_wdata,
    input  wire logic                  spl_wr,
    input  wire logic [7:0]            spl_wdata,
    input  wire logic                  stack_reset_instr,
    // Stack sequencing: one byte per cycle while busy
    input  wire cfsp_pkg::cfsp_stk_t    stk_cmd,
    input  wire logic                  stk_pop_flags,
    input  wire logic [7:0]            pop_byte,
    // Interrupts
    input  wire logic                  irq_req,
    input  wire logic                  trap_req,
    // Outputs
    output logic [7:0]                 condition_flags,
    output logic [15:0]                stack_pointer,
    output cfsp_pkg::cfsp_mem_t         stk_mem,
    output logic                       stk_busy,
    output logic                       irq_take
);
    logic [7:0]  flags_q, flags_d;
    logic [5:0]  spl_q, spl_d;
    logic [2:0]  left_q, left_d;
    logic [2:0]  idx_q, idx_d;
    logic        dir_push_q, dir_push_d;
    logic        ctx_q, ctx_d;
    logic        pend_q;
    cfsp_pkg::cfsp_mem_t mem_q, mem_d;
    logic        take_q;
    logic        busy_q;

    wire         is_push = stk_cmd == cfsp_pkg::CFSP_ST_PUSH;
    wire         is_call = stk_cmd == cfsp_pkg::CFSP_ST_CALL;
    wire         is_ient = stk_cmd == cfsp_pkg::CFSP_ST_IENTRY;
    wire         is_return_from_interrupt = stk_cmd == cfsp_pkg::CFSP_ST_RETURN_FROM_INTERRUPT;
    wire         start   = !stk_busy && stk_cmd != cfsp_pkg::CFSP_ST_NONE;
    wire         ent_go  = is_ient && start;
    wire         return_from_interrupt_go = is_return_from_interrupt && start;
    wire [5:0]   spl_inc = spl_q + 6'h01;
    wire [5:0]   spl_dec = spl_q - 6'h01;
    wire         mask_on = flags_q[cfsp_pkg::FLAG_I];
    // Trap ignores the mask; hardware requests wait for it
    wire         want    = trap_req || ((irq_req || pend_q) && !mask_on);

    function automatic logic [15:0] full_sp(input logic [5:0] low);
        full_sp = (cfsp_pkg::SP_TOP & cfsp_pkg::SP_HIGH_MASK) | {10'h000, low};
    endfunction

    function automatic logic [2:0] byte_count(input cfsp_pkg::cfsp_stk_t c);
        case (c)
            cfsp_pkg::CFSP_ST_CALL, cfsp_pkg::CFSP_ST_RET:
                byte_count = cfsp_pkg::CALL_BYTES;
            cfsp_pkg::CFSP_ST_IENTRY, cfsp_pkg::CFSP_ST_RETURN_FROM_INTERRUPT:
                byte_count = cfsp_pkg::CTX_BYTES;
            cfsp_pkg::CFSP_ST_NONE:
                byte_count = 3'h0;
            default:
                byte_count = 3'h1;
        endcase
    endfunction

    assign stk_busy = busy_q;
    wire push_dir = is_push || is_call || is_ient;
    // Read data answers the registered cycle, one clock after the step
    wire pop_ld   = mem_q.valid && !mem_q.write && stk_pop_flags;

    always_comb begin
        flags_d = flags_q;
        if (alu.upd_h)
            flags_d[cfsp_pkg::FLAG_H] = alu.half_carry;
        if (alu.upd_nz) begin
            flags_d[cfsp_pkg::FLAG_N] = alu.result[cfsp_pkg::SIGN_BIT];
            flags_d[cfsp_pkg::FLAG_Z] = alu.result == 8'h00;
        end
        if (alu.upd_c)
            flags_d[cfsp_pkg::FLAG_C] = alu.carry;
        // Set wins over clear when both arrive together
        if (flagop.clr_carry)
            flags_d[cfsp_pkg::FLAG_C] = 1'b0;
        if (flagop.set_carry)
            flags_d[cfsp_pkg::FLAG_C] = 1'b1;
        if (flags_wr)
            flags_d = flags_wdata;
        if (pop_ld)
            flags_d = pop_byte;
        if (flagop.clr_mask || return_from_interrupt_go)
            flags_d[cfsp_pkg::FLAG_I] = 1'b0;
        if (flagop.set_mask || ent_go)
            flags_d[cfsp_pkg::FLAG_I] = 1'b1;
        flags_d = flags_d | cfsp_pkg::FLAGS_FIXED;
    end

    always_comb begin
        spl_d      = spl_q;
        left_d     = left_q;
        idx_d      = idx_q;
        dir_push_d = dir_push_q;
        ctx_d      = ctx_q;
        mem_d      = '0;
        if (start) begin
            left_d     = byte_count(stk_cmd);
            idx_d      = 3'h0;
            dir_push_d = push_dir;
            ctx_d      = is_ient || is_return_from_interrupt;
        end else if (stk_busy) begin
            mem_d.valid = 1'b1;
            mem_d.write = dir_push_q;
            mem_d.index = idx_q;
            idx_d  = idx_q + 3'h1;
            left_d = left_q - 3'h1;
            if (dir_push_q) begin
                // Write at the free byte, then step down; wraps silently
                mem_d.addr = full_sp(spl_q);
                spl_d = spl_dec;
            end else begin
                mem_d.addr = full_sp(spl_inc);
                spl_d = spl_inc;
            end
        end
        if (spl_wr)
            spl_d = spl_wdata[5:0];
        if (stack_reset_instr)
            spl_d = cfsp_pkg::SP_LOW_MASK;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            flags_q    <= cfsp_pkg::FLAGS_RESET;
            spl_q      <= cfsp_pkg::SP_LOW_MASK;
            left_q     <= 3'h0;
            idx_q      <= 3'h0;
            dir_push_q <= 1'b0;
            ctx_q      <= 1'b0;
            mem_q      <= '0;
            busy_q     <= 1'b0;
        end else begin
            busy_q     <= left_d != 3'h0;
            flags_q    <= flags_d;
            spl_q      <= spl_d;
            left_q     <= left_d;
            idx_q      <= idx_d;
            dir_push_q <= dir_push_d;
            ctx_q      <= ctx_d;
            mem_q      <= mem_d;
        end
    end

    // Pending latch: a new request beats the clear by entry
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pend_q <= 1'b0;
            take_q <= 1'b0;
        end else begin
            pend_q <= irq_req || (pend_q && !(ent_go && !mask_on));
            take_q <= want && !stk_busy && !ent_go;
        end
    end

    assign condition_flags = flags_q;
    assign stack_pointer   = full_sp(spl_q);
    assign stk_mem         = mem_q;
    assign irq_take        = take_q;

    a_flags_fixed: assert property (@(posedge clk) disable iff (!rst_n)
        condition_flags[7:5] == 3'h7)
        else $error("fixed flag bits not one");
    a_half_carry: assert property (@(posedge clk) disable iff (!rst_n)
        alu.upd_h && !flags_wr && !pop_ld |=>
        condition_flags[4] == $past(alu.half_carry))
        else $error("half carry not taken");
    a_mask_entry: assert property (@(posedge clk) disable iff (!rst_n)
        ent_go |=> condition_flags[3])
        else $error("mask not set on entry");
    a_mask_return_from_interrupt: assert property (@(posedge clk) disable iff (!rst_n)
        return_from_interrupt_go && !flagop.set_mask && !flags_wr && !pop_ld |=>
        !condition_flags[3])
        else $error("mask not cleared on return");
    a_pend_hold: assert property (@(posedge clk) disable iff (!rst_n)
        irq_req |=> pend_q)
        else $error("request lost");
    a_neg_zero: assert property (@(posedge clk) disable iff (!rst_n)
        alu.upd_nz && !flags_wr && !pop_ld |=>
        condition_flags[2] == $past(alu.result[7]) &&
        condition_flags[1] == ($past(alu.result) == 8'h00))
        else $error("n or z wrong");
    a_sp_high: assert property (@(posedge clk) disable iff (!rst_n)
        stack_pointer[15:6] == 10'h005)
        else $error("pointer high bits moved");
    a_sp_rst: assert property (@(posedge clk) disable iff (!rst_n)
        stack_reset_instr |=> stack_pointer == 16'h017F)
        else $error("stack reset failed");
    sequence s_ient;
        ent_go ##1 stk_busy [*5];
    endsequence
    a_ctx_five: assert property (@(posedge clk) disable iff (!rst_n)
        s_ient |=> !stk_busy)
        else $error("entry not five bytes");
    a_push_wrap: assert property (@(posedge clk) disable iff (!rst_n)
        stk_busy && dir_push_q && spl_q == 6'h00 && !spl_wr &&
        !stack_reset_instr |=> spl_q == 6'h3F)
        else $error("no wrap");
    a_carry_set: assert property (@(posedge clk) disable iff (!rst_n)
        flagop.set_carry && !flags_wr && !pop_ld |=>
        condition_flags[0])
        else $error("carry not set");
    a_trap_take: assert property (@(posedge clk) disable iff (!rst_n)
        trap_req && !stk_busy && !ent_go |=> irq_take)
        else $error("trap not taken");
endmodule

// ==== sim/cfsp_ram_model.sv ====
`timescale 1ns/1ps
module cfsp_ram_model (
    // Stack cycle from the block
    input  wire logic                 clk,
    input  wire cfsp_pkg::cfsp_mem_t  stk_mem,
    // Byte returned on a read cycle
    output logic [7:0]                pop_byte
);
    logic [7:0] last_q = 8'h00;
    wire        rd     = stk_mem.valid && !stk_mem.write;
    // Content follows the address; when idle the bus toggles, never holds
    assign pop_byte = rd ? (stk_mem.addr[7:0] ^ 8'h5A) : ~last_q;
    always @(posedge clk) begin
        last_q <= pop_byte;
    end
endmodule

// ==== sim/tb_cfsp_regs.sv ====
`timescale 1ns/1ps
module tb_cfsp_regs;
    logic clk = 1'b0, rst_n = 1'b0, flags_wr = 1'b0, spl_wr = 1'b0;
    logic stack_reset_instr = 1'b0, stk_pop_flags = 1'b0;
    logic irq_req = 1'b0, trap_req = 1'b0, stk_busy, irq_take;
    logic [7:0] flags_wdata = 8'h00, spl_wdata = 8'h00, pop_byte;
    logic [7:0] condition_flags;
    logic [15:0] stack_pointer;
    cfsp_pkg::cfsp_alu_t alu = '0;
    cfsp_pkg::cfsp_flagop_t flagop = '0;
    cfsp_pkg::cfsp_stk_t stk_cmd = cfsp_pkg::CFSP_ST_NONE;
    cfsp_pkg::cfsp_mem_t stk_mem;
    int n_mismatch = 0, n_checks = 0;
    logic [19:0] log_q[$];
    // Rows: alu request, flag instruction, expected flags
    logic [24:0] rows[7] = '{{13'h1C03, 4'h0, 8'hFB}, {13'h1E00, 4'h0, 8'hEC},
        {13'h1004, 4'h0, 8'hE8}, {13'h0000, 4'h2, 8'hE9},
        {13'h0000, 4'h1, 8'hE8}, {13'h0000, 4'h4, 8'hE0},
        {13'h0000, 4'h8, 8'hE8}};

    always #25 clk = ~clk;
    always @(posedge clk) begin
        if (stk_mem.valid === 1'b1)
            log_q.push_back({stk_mem.write, stk_mem.index, stk_mem.addr});
    end

    cfsp_regs i_cfsp_regs (.clk(clk), .rst_n(rst_n), .alu(alu),
        .flagop(flagop), .flags_wr(flags_wr), .flags_wdata(flags_wdata),
        .spl_wr(spl_wr), .spl_wdata(spl_wdata),
        .stack_reset_instr(stack_reset_instr), .stk_cmd(stk_cmd),
        .stk_pop_flags(stk_pop_flags), .pop_byte(pop_byte),
        .irq_req(irq_req), .trap_req(trap_req),
        .condition_flags(condition_flags), .stack_pointer(stack_pointer),
        .stk_mem(stk_mem), .stk_busy(stk_busy), .irq_take(irq_take));
    cfsp_ram_model i_cfsp_ram_model (.clk(clk), .stk_mem(stk_mem),
        .pop_byte(pop_byte));

    task automatic chk(input string name, input logic [19:0] got,
                       input logic [19:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // One stack operation; bounded wait for busy to rise and fall again
    task automatic run(input cfsp_pkg::cfsp_stk_t cmd);
        bit seen;
        seen = 1'b0;
        @(negedge clk) stk_cmd = cmd;
        @(negedge clk) stk_cmd = cfsp_pkg::CFSP_ST_NONE;
        for (int k = 0; k < 20; k++) begin
            if (stk_busy === 1'b1) seen = 1'b1;
            else if (seen) return;
            @(negedge clk);
        end
        n_mismatch++;
        end_sim();
    endtask

    task automatic pulse(ref logic s);
        @(negedge clk) s = 1'b1;
        @(negedge clk) s = 1'b0;
    endtask

    initial begin
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        chk("flags", condition_flags, 8'hE8);
        chk("sp", stack_pointer, 16'h017F);
        foreach (rows[i]) begin
            @(negedge clk);
            alu = cfsp_pkg::cfsp_alu_t'(rows[i][24:12]);
            flagop = cfsp_pkg::cfsp_flagop_t'(rows[i][11:8]);
            @(negedge clk) {alu, flagop} = '0;
            chk("row", condition_flags, rows[i][7:0]);
        end
        pulse(flags_wr);
        chk("wr00", condition_flags, 8'hE0);
        run(cfsp_pkg::CFSP_ST_PUSH);
        chk("push", stack_pointer, 16'h017E);
        run(cfsp_pkg::CFSP_ST_CALL);
        chk("call", stack_pointer, 16'h017C);
        pulse(stack_reset_instr);
        chk("rsp", stack_pointer, 16'h017F);
        log_q.delete();
        run(cfsp_pkg::CFSP_ST_IENTRY);
        @(negedge clk);
        chk("entry", stack_pointer, 16'h017A);
        chk("mask", condition_flags[3], 1'b1);
        chk("nbytes", log_q.size(), 5);
        foreach (log_q[i])
            chk("ctx", log_q[i], {1'b1, 3'(i), 16'h017F - 16'(i)});
        @(negedge clk) trap_req = 1'b1;
        @(negedge clk) trap_req = 1'b0;
        chk("trap", irq_take, 1'b1);
        @(negedge clk) irq_req = 1'b1;
        repeat (3) @(negedge clk);
        chk("held", irq_take, 1'b0);
        flagop.clr_mask = 1'b1;
        @(negedge clk) flagop = '0;
        repeat (2) @(negedge clk);
        chk("take", irq_take, 1'b1);
        irq_req = 1'b0;
        run(cfsp_pkg::CFSP_ST_RETURN_FROM_INTERRUPT);
        chk("return_from_interrupt", stack_pointer, 16'h017F);
        pulse(spl_wr);
        chk("ld", stack_pointer, 16'h0140);
        run(cfsp_pkg::CFSP_ST_PUSH);
        chk("wrap", stack_pointer, 16'h017F);
        stk_pop_flags = 1'b1;
        run(cfsp_pkg::CFSP_ST_POP);
        @(negedge clk) stk_pop_flags = 1'b0;
        chk("pop", stack_pointer, 16'h0140);
        chk("popcc", condition_flags, 8'hFA);
        rst_n = 1'b0;
        repeat (2) @(negedge clk);
        chk("rflags", condition_flags, 8'hE8);
        chk("rsp2", stack_pointer, 16'h017F);
        end_sim();
    end
endmodule
